// ### verilog/scs_pkg.sv
/*
  package for the checksum arm and serial error flag registers.
  assumes a register port from the serial frame engine, one clock domain.
*/
package scs_pkg;
  // ==========================================================
  // addresses
  localparam logic [7:0] SCS_ADDR_ARM    = 8'h10;
  localparam logic [7:0] SCS_ADDR_STATUS = 8'h11;
  // ==========================================================
  // reset values
  localparam logic [7:0] SCS_ARM_RST    = 8'h03;
  localparam logic [7:0] SCS_STATUS_RST = 8'h00;
  // ==========================================================
  // arm fields
  localparam int         SCS_EN_LSB    = 6;
  localparam int         SCS_ENN_LSB   = 0;
  localparam logic [1:0] SCS_EN_ON     = 2'h1;
  localparam logic [1:0] SCS_ENN_ON    = 2'h2;
  localparam logic [1:0] SCS_EN_RST    = 2'h0;
  localparam logic [1:0] SCS_ENN_RST   = 2'h3;
  // ==========================================================
  // status bit positions
  localparam int SCS_NOT_RDY_BIT  = 7;
  localparam int SCS_CLK_CNT_BIT  = 4;
  localparam int SCS_CRC_BIT      = 3;
endpackage

// ### verilog/scs_regs.sv
/*
  checksum arm control and serial error flag registers, with the sticky flag cell they use.
  assumes the frame engine presents one-cycle write and read strobes with
  an address and data byte, and one-cycle error set pulses, all synchronous.
*/
// Contract
// R01: checking on only when enable field is 1 and inverse field is 2.
// R02: arm control register at 0x10, resets to 0x03, checking off.
// R03: arm control bits 5:2 read zero and cannot be written.
// R04: early-access flag sets when a transaction starts before device ready.
// R05: early-access flag resets zero, sticky, cleared only by writing one.
// R06: status register at 0x11 resets to 0x00, reserved bits read-only.
// R07: checksum mismatch flag sets while checking active, write one clears.
// R08: clock-count flag sets on wrong serial clock edge count.
// R09: writes to reserved bits ignored, writable neighbours still update.
module scs_regs
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // register port
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  // events from frame engine
  input  wire logic       frame_start_i,
  input  wire logic       dev_ready_i,
  input  wire logic       crc_mismatch_i,
  input  wire logic       clk_count_err_i,
  // results
  output logic            crc_check_en_o,
  output logic      [7:0] status_o
);
  // ==========================================================
  // elaboration checks
  // the field layout is fixed by the register map; refuse a package that breaks it
  if (SCS_EN_LSB + 2 > 8 || SCS_ENN_LSB + 2 > 8) begin
    $error("arm control fields must lie inside one byte");
  end
  if (SCS_ENN_LSB + 2 > SCS_EN_LSB && SCS_EN_LSB + 2 > SCS_ENN_LSB) begin
    $error("arm control fields must not overlap");
  end
  if (SCS_ARM_RST[SCS_EN_LSB +: 2] != SCS_EN_RST) begin
    $error("arm control reset word disagrees with the enable field reset");
  end
  if (SCS_ARM_RST[SCS_ENN_LSB +: 2] != SCS_ENN_RST) begin
    $error("arm control reset word disagrees with the inverse field reset");
  end
  if (SCS_EN_RST == SCS_EN_ON && SCS_ENN_RST == SCS_ENN_ON) begin
    $error("checking must come out of reset disabled");
  end
  if (SCS_NOT_RDY_BIT > 7 || SCS_CLK_CNT_BIT > 7 || SCS_CRC_BIT > 7) begin
    $error("status flags must lie inside one byte");
  end
  if (SCS_NOT_RDY_BIT == SCS_CLK_CNT_BIT || SCS_NOT_RDY_BIT == SCS_CRC_BIT
      || SCS_CLK_CNT_BIT == SCS_CRC_BIT) begin
    $error("status flags need distinct positions");
  end
  if (SCS_ADDR_ARM == SCS_ADDR_STATUS) begin
    $error("the two registers need distinct addresses");
  end

  // ==========================================================
  // address decode
  logic hit_arm;
  logic hit_stat;
  logic wr_arm;
  logic wr_stat;

  assign hit_arm  = (addr_i == SCS_ADDR_ARM);
  assign hit_stat = (addr_i == SCS_ADDR_STATUS);
  // unmapped writes fall through both decodes and change nothing
  assign wr_arm   = wr_i && hit_arm;
  assign wr_stat  = wr_i && hit_stat;

  // ==========================================================
  // arm control register
  logic [1:0] en_field;
  logic [1:0] enn_field;
  logic [1:0] next_en_field;
  logic [1:0] next_enn_field;

  // bits 5:2 have no storage at all, so a write can never reach them
  always_comb begin
    next_en_field  = en_field;
    next_enn_field = enn_field;
    if (wr_arm) begin
      next_en_field  = wdata_i[SCS_EN_LSB +: 2]; // R09
      next_enn_field = wdata_i[SCS_ENN_LSB +: 2]; // R09
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      en_field  <= SCS_EN_RST; // R02
      enn_field <= SCS_ENN_RST; // R02
    end else begin
      en_field  <= next_en_field;
      enn_field <= next_enn_field;
    end
  end

  // ==========================================================
  // checksum enable
  logic next_crc_check_en;

  // both fields must agree; a single upset bit leaves checking off
  assign next_crc_check_en = (en_field == SCS_EN_ON) && (enn_field == SCS_ENN_ON); // R01

  // registered so the frame engine sees a clean level, one cycle after the fields
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      crc_check_en_o <= 1'b0; // R02
    end else begin
      crc_check_en_o <= next_crc_check_en;
    end
  end

  // ==========================================================
  // sticky error flags
  logic set_not_rdy;
  logic set_clk_cnt;
  logic set_crc_err;
  logic clr_not_rdy;
  logic clr_clk_cnt;
  logic clr_crc_err;
  logic not_rdy;
  logic clk_cnt;
  logic crc_err;

  // a transaction that arrives too early is only flagged, never refused
  assign set_not_rdy = frame_start_i && !dev_ready_i; // R04
  assign set_clk_cnt = clk_count_err_i; // R08
  // mismatches seen while checking is off are not errors
  assign set_crc_err = crc_mismatch_i && crc_check_en_o; // R07
  // a written zero leaves a flag alone
  assign clr_not_rdy = wr_stat && wdata_i[SCS_NOT_RDY_BIT]; // R05
  assign clr_clk_cnt = wr_stat && wdata_i[SCS_CLK_CNT_BIT];
  assign clr_crc_err = wr_stat && wdata_i[SCS_CRC_BIT]; // R07

  scs_sticky_flag #(.RST_VAL(SCS_STATUS_RST[SCS_NOT_RDY_BIT])) i_flag_not_rdy (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .set_i     (set_not_rdy),
    .clr_i     (clr_not_rdy),
    .flag_o    (not_rdy)
  );

  scs_sticky_flag #(.RST_VAL(SCS_STATUS_RST[SCS_CLK_CNT_BIT])) i_flag_clk_cnt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .set_i     (set_clk_cnt),
    .clr_i     (clr_clk_cnt),
    .flag_o    (clk_cnt)
  );

  scs_sticky_flag #(.RST_VAL(SCS_STATUS_RST[SCS_CRC_BIT])) i_flag_crc_err (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .set_i     (set_crc_err),
    .clr_i     (clr_crc_err),
    .flag_o    (crc_err)
  );

  // ==========================================================
  // status word
  logic [7:0] status_word;

  // reserved positions keep their reset value, which is zero
  always_comb begin
    status_word                  = SCS_STATUS_RST; // R06
    status_word[SCS_NOT_RDY_BIT] = not_rdy;
    status_word[SCS_CLK_CNT_BIT] = clk_cnt;
    status_word[SCS_CRC_BIT]     = crc_err;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      status_o <= SCS_STATUS_RST; // R06
    end else begin
      status_o <= status_word;
    end
  end

  // ==========================================================
  // read path
  logic [7:0] arm_word;
  logic [7:0] next_rdata;

  // reserved arm bits are tied low here rather than stored
  always_comb begin
    arm_word                   = 8'h00; // R03
    arm_word[SCS_EN_LSB +: 2]  = en_field;
    arm_word[SCS_ENN_LSB +: 2] = enn_field;
  end

  // unmapped addresses return zero; rdata_o holds until the next read
  always_comb begin
    next_rdata = rdata_o;
    if (rd_i) begin
      unique case (addr_i)
        SCS_ADDR_ARM:    next_rdata = arm_word; // R03
        SCS_ADDR_STATUS: next_rdata = status_word; // R06
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // one answer per read strobe, one cycle later
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
    end
  end
endmodule

// ==========================================================
// sticky flag cell: set by hardware, cleared by writing one
module scs_sticky_flag
  import scs_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // set and clear requests
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  logic next_flag;

  // set wins, so an error landing on the clearing write is not lost
  always_comb begin
    next_flag = flag_o;
    if (set_i) begin
      next_flag = 1'b1;
    end else if (clr_i) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flag_o <= RST_VAL; // R05
    end else begin
      flag_o <= next_flag;
    end
  end
endmodule

// ### tb/scs_host.sv
/* host model issuing single register accesses; assumes calls between clock edges. */
module scs_host (
  input  wire logic       sys_clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  // released address and data lines show the inverse, never the old value; wr_o and rd_o drop low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i) {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, v};
    @(posedge sys_clk_i) {wr_o, rd_o, addr_o, wdata_o} <= {2'h0, ~a, ~v};
  endtask
endmodule

// ### tb/scs_regs_checker.sv
/* checker on scs_regs ports; assumes one clock domain. */
module scs_regs_checker (
  input wire logic       sys_clk_i, resetn_i, wr_i, rd_i, frame_start_i, dev_ready_i,
  input wire logic       crc_mismatch_i, clk_count_err_i, crc_check_en_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire arm_w = wr_i && addr_i == 8'h10;
  wire clr_r = wr_i && addr_i == 8'h11 && wdata_i[7];
  a_arm_pair: assert property (arm_w ##1 !arm_w |=> crc_check_en_o ==
    (($past(wdata_i, 2) & 8'hc3) == 8'h42)) else $error("arm");
  a_reset_vals: assert property ($rose(resetn_i) |-> status_o == 8'h00
    && !crc_check_en_o) else $error("rst");
  a_arm_rsvd: assert property (rd_i && addr_i == 8'h10 |=> rdata_o[5:2] == 4'h0)
    else $error("rsv");
  a_stat_rsvd: assert property ((status_o & 8'h67) == 8'h00) else $error("st");
  a_not_rdy: assert property (frame_start_i && !dev_ready_i |-> ##2 status_o[7])
    else $error("nr");
  a_clk_cnt: assert property (clk_count_err_i |-> ##2 status_o[4]) else $error("cc");
  a_crc_set: assert property (crc_mismatch_i && crc_check_en_o |-> ##2 status_o[3])
    else $error("crc");
  a_stay_set: assert property ($fell(status_o[7]) |-> $past(clr_r, 2)) else $error("w");
endmodule
bind scs_regs scs_regs_checker i_chk (.sys_clk_i, .resetn_i, .wr_i, .rd_i, .frame_start_i,
  .dev_ready_i, .crc_mismatch_i, .clk_count_err_i, .crc_check_en_o, .addr_i, .wdata_i,
  .rdata_o, .status_o);

// ### tb/tb.sv
/* bench for scs_regs; assumes the bound checker and the scs_host model. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_i = 0, resetn_i = 0, frame_start_i = 0, dev_ready_i = 1;
  logic       crc_mismatch_i = 0, clk_count_err_i = 0, wr_i, rd_i, rvalid_o;
  logic [7:0] addr_i, wdata_i, rdata_o, exp_q[$];
  int         fails = 0, checked = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  scs_host i_scs_host (.sys_clk_i, .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
  scs_regs i_scs_regs (.sys_clk_i, .resetn_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .rvalid_o, .frame_start_i, .dev_ready_i, .crc_mismatch_i, .clk_count_err_i,
    .crc_check_en_o(), .status_o());
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    i_scs_host.acc(1'b0, a, 8'h00);
  endtask
  // error events pulse for one cycle
  task automatic ev(input logic [2:0] e);
    @(posedge sys_clk_i) {frame_start_i, crc_mismatch_i, clk_count_err_i} <= e;
    @(posedge sys_clk_i) {frame_start_i, crc_mismatch_i, clk_count_err_i} <= 3'h0;
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) fails++;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(negedge sys_clk_i) if (rvalid_o === 1'b1) check(rdata_o, exp_q.pop_front());
  initial begin
    void'($urandom(32'h4689a795));
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1;
    rd(8'h10, 8'h03);
    rd(8'h11, 8'h00);
    for (int i = 0; i < 16; i++) begin
      i_scs_host.acc(1'b1, 8'h10, {i[3:2], 4'($urandom), i[1:0]});
      rd(8'h10, {i[3:2], 4'h0, i[1:0]});
    end
    i_scs_host.acc(1'b1, 8'h10, 8'h42);
    repeat (2) @(posedge sys_clk_i);
    ev(3'h7);
    rd(8'h11, 8'h18);
    dev_ready_i <= 0;
    ev(3'h4);
    rd(8'h11, 8'h98);
    i_scs_host.acc(1'b1, 8'h11, 8'h10);
    rd(8'h11, 8'h88);
    fork
      ev(3'h1);
      i_scs_host.acc(1'b1, 8'h11, 8'h10);
    join
    rd(8'h11, 8'h98);
    i_scs_host.acc(1'b1, 8'h10, 8'h03);
    i_scs_host.acc(1'b1, 8'h11, 8'hff);
    ev(3'h2);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    i_scs_host.acc(1'b1, 8'h10, 8'hff);
    ev(3'h1);
    resetn_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1;
    rd(8'h10, 8'h03);
    rd(8'h11, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    conclude();
  end
  initial begin
    #2000;
    fails++;
    conclude();
  end
endmodule
